// [core/ivc_pkg.sv]
/*
 * Shared constants and carrier types for the vectored interrupt controller.
 * Assumes a single clock domain and request lines from logic on that clock.
 */
`default_nettype none
package ivc_pkg;
    localparam int IVC_NUM_CHAN = 32;
    localparam int IVC_IDX_W = 5;
    localparam int IVC_VEC_W = 32;
    localparam logic [IVC_IDX_W-1:0] IVC_IDX_RST = 5'h00;
    localparam logic [IVC_VEC_W-1:0] IVC_VEC_RST = 32'h00000000;
    localparam logic [IVC_NUM_CHAN-1:0] IVC_NONE = 32'h00000000;
    localparam logic [IVC_NUM_CHAN-1:0] IVC_ONE = 32'h00000001;

    typedef struct packed {
        logic valid;
        logic none;
        logic [IVC_IDX_W-1:0] channel;
        logic [IVC_IDX_W-1:0] source;
        logic [IVC_VEC_W-1:0] vector;
    } ivc_answer_type;

    typedef struct packed {
        logic en;
        logic [IVC_IDX_W-1:0] idx;
        logic [IVC_VEC_W-1:0] data;
    } ivc_vec_wr_type;
endpackage
`default_nettype wire

// [core/ivc_top.sv]
/*
 * Vectored interrupt controller: 32 prioritised channels, a fast direct
 * output and a vectored normal output with identity and vector readout.
 * Assumes request, configuration and service strobes all come from logic
 * on CORE_CLK_I, so none of them is synchronised here.
 */
// Contract
// - There are 32 request channels, each with its own fixed priority, in one combined unit.
// - Only a fast and a normal interrupt are driven, and the fast one takes precedence.
// - The fast interrupt carries no vector and needs no readout to be served.
// - Software may route any one of the 32 request inputs to the fast interrupt.
// - The normal interrupt is the OR of the requests on all vectored channels.
// - Channel 0 has the highest vectored priority and channel 31 the lowest.
// - Software chooses which source feeds each channel and so sets its priority.
// - When the normal interrupt is up, the highest-priority pending channel above any in-service channel is resolved.
// - A service read returns the winning source identity and its vector address.
// - Software may force a request on any channel regardless of its source.
`timescale 1ns/1ns
`default_nettype none
module ivc_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [ivc_pkg::IVC_NUM_CHAN-1:0] SRC_REQ_I,
    input wire logic [ivc_pkg::IVC_NUM_CHAN-1:0][ivc_pkg::IVC_IDX_W-1:0] CHAN_SRC_SEL_I,
    input wire logic [ivc_pkg::IVC_NUM_CHAN-1:0] SOFT_FORCE_I,
    input wire logic FAST_EN_I,
    input wire logic [ivc_pkg::IVC_IDX_W-1:0] FAST_SRC_SEL_I,
    input wire ivc_pkg::ivc_vec_wr_type VEC_WR_I,
    input wire logic SERVICE_RD_I,
    input wire logic SERVICE_DONE_I,
    output logic FAST_IRQ_O,
    output logic NORMAL_IRQ_O,
    output ivc_pkg::ivc_answer_type ANSWER_O
);
    logic [ivc_pkg::IVC_NUM_CHAN-1:0] chan_req;
    logic [ivc_pkg::IVC_NUM_CHAN-1:0] allow_mask;
    logic [ivc_pkg::IVC_NUM_CHAN-1:0] eligible;
    logic [ivc_pkg::IVC_IDX_W-1:0] win;
    logic fast_hit;
    logic [ivc_pkg::IVC_NUM_CHAN-1:0] fast_clash;
    logic busy_reg;
    logic [ivc_pkg::IVC_IDX_W-1:0] busy_chan_reg;
    logic valid_reg;
    logic none_reg;
    logic [ivc_pkg::IVC_IDX_W-1:0] chan_reg;
    logic [ivc_pkg::IVC_IDX_W-1:0] src_reg;
    logic [ivc_pkg::IVC_VEC_W-1:0] vec_rdata;

    // Priority find: lowest set index wins
    function automatic logic [ivc_pkg::IVC_IDX_W-1:0] first_set(
        input logic [ivc_pkg::IVC_NUM_CHAN-1:0] v
    );
        logic [ivc_pkg::IVC_IDX_W-1:0] r;
        r = ivc_pkg::IVC_IDX_RST;
        for (int i = ivc_pkg::IVC_NUM_CHAN - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = ivc_pkg::IVC_IDX_W'(i);
            end
        end
        return r;
    endfunction

    // Bits strictly above the given channel in priority
    function automatic logic [ivc_pkg::IVC_NUM_CHAN-1:0] above_mask(
        input logic [ivc_pkg::IVC_IDX_W-1:0] idx
    );
        return (ivc_pkg::IVC_ONE << idx) - ivc_pkg::IVC_ONE;
    endfunction

    assign fast_hit = FAST_EN_I && SRC_REQ_I[FAST_SRC_SEL_I];

    // A source routed to the fast output is kept off every vectored channel
    generate
        for (genvar c = 0; c < ivc_pkg::IVC_NUM_CHAN; c++) begin : g_chan
            logic routed_fast;
            assign routed_fast = FAST_EN_I && (CHAN_SRC_SEL_I[c] == FAST_SRC_SEL_I);
            assign fast_clash[c] = routed_fast;
            assign chan_req[c] = (SRC_REQ_I[CHAN_SRC_SEL_I[c]] && !routed_fast)
                || SOFT_FORCE_I[c];
        end
    endgenerate

    assign allow_mask = busy_reg ? above_mask(busy_chan_reg) : ~ivc_pkg::IVC_NONE;
    assign eligible = chan_req & allow_mask;
    assign win = first_set(eligible);

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FAST_IRQ_O <= 1'b0;
        end else begin
            FAST_IRQ_O <= fast_hit;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            NORMAL_IRQ_O <= 1'b0;
        end else begin
            NORMAL_IRQ_O <= |chan_req;
        end
    end

    // In service: a read that resolves a channel wins over a completion in the same cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            busy_reg <= 1'b0;
            busy_chan_reg <= ivc_pkg::IVC_IDX_RST;
        end else if (SERVICE_RD_I && (eligible != ivc_pkg::IVC_NONE)) begin
            busy_reg <= 1'b1;
            busy_chan_reg <= win;
        end else if (SERVICE_DONE_I) begin
            busy_reg <= 1'b0;
        end
    end

    // Pulse only: valid is high in the single cycle after the taking edge
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= SERVICE_RD_I;
        end
    end

    // Fields hold between reads so a slow handler can still pick them up
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            none_reg <= 1'b0;
            chan_reg <= ivc_pkg::IVC_IDX_RST;
            src_reg <= ivc_pkg::IVC_IDX_RST;
        end else if (SERVICE_RD_I) begin
            none_reg <= (eligible == ivc_pkg::IVC_NONE);
            chan_reg <= win;
            src_reg <= CHAN_SRC_SEL_I[win];
        end
    end

    // Read launched on the resolving edge, so the vector lands beside valid
    ivc_vec_mem u_vec_mem (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .wr_i(VEC_WR_I),
        .rd_en_i(SERVICE_RD_I),
        .rd_idx_i(win),
        .rd_data_o(vec_rdata)
    );

    assign ANSWER_O = '{valid: valid_reg, none: none_reg, channel: chan_reg,
                        source: src_reg, vector: vec_rdata};

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_fast_route: assert property (fast_hit |=> FAST_IRQ_O)
        else $error("fast output missed its routed source");
    a_fast_direct: assert property (!fast_hit |=> !FAST_IRQ_O)
        else $error("fast output raised without routed source");
    a_fast_off: assert property (!FAST_EN_I |=> !FAST_IRQ_O)
        else $error("fast output raised while routing is off");
    a_fast_excl: assert property (FAST_EN_I
        |-> (chan_req & fast_clash & ~SOFT_FORCE_I) == ivc_pkg::IVC_NONE)
        else $error("fast source also requested a vectored channel");
    a_normal_or: assert property ((chan_req != ivc_pkg::IVC_NONE) |=> NORMAL_IRQ_O)
        else $error("normal output low with a channel pending");
    a_normal_idle: assert property ((chan_req == ivc_pkg::IVC_NONE) |=> !NORMAL_IRQ_O)
        else $error("normal output high with nothing pending");
    a_normal_force: assert property (SOFT_FORCE_I != ivc_pkg::IVC_NONE |=> NORMAL_IRQ_O)
        else $error("forced request did not raise the normal output");

    a_answer_time: assert property (SERVICE_RD_I
        |=> ANSWER_O.valid ##1 ANSWER_O.valid == $past(SERVICE_RD_I))
        else $error("service read not answered in one cycle");
    a_no_stray_ans: assert property (!SERVICE_RD_I |=> !ANSWER_O.valid)
        else $error("answer without a service read");
    a_answer_src: assert property (SERVICE_RD_I
        |=> ANSWER_O.source == $past(CHAN_SRC_SEL_I[win]))
        else $error("answer source differs from the winning channel source");
    a_answer_hold: assert property (!SERVICE_RD_I
        |=> $stable(ANSWER_O.none) && $stable(ANSWER_O.channel)
        && $stable(ANSWER_O.source) && $stable(ANSWER_O.vector))
        else $error("answer fields changed without a service read");
    a_winner_top: assert property (eligible != ivc_pkg::IVC_NONE
        |-> eligible[win] && (eligible & above_mask(win)) == ivc_pkg::IVC_NONE)
        else $error("resolved channel is not the highest pending");
    a_winner_held: assert property (SERVICE_RD_I && eligible != ivc_pkg::IVC_NONE
        |=> ANSWER_O.channel == $past(win) && !ANSWER_O.none)
        else $error("answer channel differs from resolved channel");
    a_none_flag: assert property (SERVICE_RD_I && eligible == ivc_pkg::IVC_NONE
        |=> ANSWER_O.none && ANSWER_O.channel == ivc_pkg::IVC_IDX_RST)
        else $error("empty resolution not flagged in the answer");
    a_idle_open: assert property (!busy_reg && SERVICE_RD_I
        && chan_req != ivc_pkg::IVC_NONE |=> !ANSWER_O.none)
        else $error("pending request not resolved while idle");

    a_force_chan: assert property (SOFT_FORCE_I != ivc_pkg::IVC_NONE
        |-> (SOFT_FORCE_I & ~chan_req) == ivc_pkg::IVC_NONE)
        else $error("forced channel not requesting");
    a_route_map: assert property (!FAST_EN_I && !SOFT_FORCE_I[0]
        |-> chan_req[0] == SRC_REQ_I[CHAN_SRC_SEL_I[0]])
        else $error("channel does not follow its chosen source");
    a_done_clears: assert property (SERVICE_DONE_I && !SERVICE_RD_I |=> !busy_reg)
        else $error("completion did not reopen lower channels");
    a_busy_mark: assert property (SERVICE_RD_I && eligible != ivc_pkg::IVC_NONE
        |=> busy_reg && busy_chan_reg == $past(win))
        else $error("winning read did not mark its channel in service");
    a_busy_hold: assert property (busy_reg && !SERVICE_RD_I && !SERVICE_DONE_I
        |=> busy_reg && $stable(busy_chan_reg))
        else $error("in-service channel dropped without completion");
    a_lower_masked: assert property (busy_reg && SERVICE_RD_I
        |=> ANSWER_O.none || ANSWER_O.channel < $past(busy_chan_reg))
        else $error("lower channel resolved while in service");

    // Own disable clause: every check above is switched off while reset is low
    a_reset_quiet: assert property (disable iff (1'b0) !RST_N_I
        |=> !FAST_IRQ_O && !NORMAL_IRQ_O && ANSWER_O == '0)
        else $error("outputs not cleared by reset");

    c_fast: cover property (fast_hit ##1 FAST_IRQ_O);
    c_read: cover property (NORMAL_IRQ_O ##1 SERVICE_RD_I ##1 ANSWER_O.valid);
    c_nest: cover property (busy_reg && SERVICE_RD_I && eligible != ivc_pkg::IVC_NONE);
    c_done: cover property (busy_reg ##1 SERVICE_DONE_I ##1 !busy_reg);
    c_none: cover property (SERVICE_RD_I && eligible == ivc_pkg::IVC_NONE);
endmodule
`default_nettype wire

// [core/ivc_vec_mem.sv]
/*
 * Vector address table, one word per channel, registered read port.
 * Assumes writer and reader share the core clock; read data hold between reads.
 */
`timescale 1ns/1ns
`default_nettype none
module ivc_vec_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ivc_pkg::ivc_vec_wr_type wr_i,
    input wire logic rd_en_i,
    input wire logic [ivc_pkg::IVC_IDX_W-1:0] rd_idx_i,
    output logic [ivc_pkg::IVC_VEC_W-1:0] rd_data_o
);
    logic [ivc_pkg::IVC_VEC_W-1:0] table_reg [ivc_pkg::IVC_NUM_CHAN];

    // No reset on the array itself: firmware loads it during initialisation
    always_ff @(posedge clk_i) begin
        if (wr_i.en) begin
            table_reg[wr_i.idx] <= wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= ivc_pkg::IVC_VEC_RST;
        end else if (rd_en_i) begin
            rd_data_o <= table_reg[rd_idx_i];
        end
    end
endmodule
`default_nettype wire

// [dv/ivc_core_model.sv]
/*
 * Processor core side: issues service reads and completion strobes.
 * Assumes the bench calls its tasks from one process, clocked by the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module ivc_core_model (
    input wire logic clk_i,
    input wire ivc_pkg::ivc_answer_type answer_i,
    output logic rd_o,
    output logic done_o
);
    initial begin
        rd_o = 1'b0;
        done_o = 1'b0;
    end

    // Strobe is held over exactly one rising edge, then the answer is awaited
    task automatic read_ack(output ivc_pkg::ivc_answer_type ans);
        int n;
        n = 0;
        @(negedge clk_i);
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        while (answer_i.valid !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n++;
        end
        ans = answer_i;
    endtask

    task automatic signal_done();
        @(negedge clk_i);
        done_o = 1'b1;
        @(negedge clk_i);
        done_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/ivc_top_bench.sv]
/*
 * Self-checking bench for the interrupt controller with a reference model.
 * Assumes the design registers every output one edge after its inputs.
 */
`timescale 1ns/1ns
`default_nettype none
module ivc_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] src = '0;
    logic [31:0] frc = '0;
    logic [31:0] lfsr = 32'h0000000C;
    logic [31:0][4:0] sel = '0;
    logic fast_en = 1'b0;
    logic [4:0] fast_sel = 5'h00;
    ivc_pkg::ivc_vec_wr_type vwr = '0;
    logic rd, done, fast_irq, normal_irq;
    ivc_pkg::ivc_answer_type answer;
    logic [31:0] tbl [32];
    logic busy = 1'b0;
    int bchan = 0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    ivc_top u_ivc_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SRC_REQ_I(src),
        .CHAN_SRC_SEL_I(sel), .SOFT_FORCE_I(frc), .FAST_EN_I(fast_en),
        .FAST_SRC_SEL_I(fast_sel), .VEC_WR_I(vwr), .SERVICE_RD_I(rd),
        .SERVICE_DONE_I(done), .FAST_IRQ_O(fast_irq), .NORMAL_IRQ_O(normal_irq),
        .ANSWER_O(answer));

    ivc_core_model u_ivc_core_model (.clk_i(clk), .answer_i(answer), .rd_o(rd),
        .done_o(done));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Fast-routed source is withheld from the vectored channels
    function automatic logic [31:0] chan_req();
        logic [31:0] r;
        for (int c = 0; c < 32; c++) begin
            r[c] = (src[sel[c]] && !(fast_en && sel[c] == fast_sel)) || frc[c];
        end
        return r;
    endfunction

    // Wide enough for both interrupt bits in front of the whole answer
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        ivc_pkg::ivc_answer_type ans, exp;
        logic [31:0] req;
        int w;
        repeat (10) @(negedge clk);
        chk({fast_irq, normal_irq, answer}, '0);
        rst_n = 1'b1;
        for (int c = 0; c < 32; c++) begin
            lfsr = next_rand(lfsr);
            tbl[c] = lfsr;
            vwr = '{1'b1, c[4:0], lfsr};
            @(negedge clk);
        end
        vwr.en = 1'b0;
        for (int i = 0; i < 70; i++) begin
            // Mid-run reset: outputs and in-service state clear, vector table survives
            if (i == 35) begin
                rst_n = 1'b0;
                repeat (2) @(negedge clk);
                chk({fast_irq, normal_irq, answer}, '0);
                rst_n = 1'b1;
                busy = 1'b0;
            end
            lfsr = next_rand(lfsr);
            for (int c = 0; c < 32; c++) sel[c] = c[4:0] ^ lfsr[20:16];
            src = (i % 9 == 0) ? '0 : lfsr & {lfsr[15:0], lfsr[31:16]} & {lfsr[7:0], lfsr[31:8]};
            frc = (i % 4 == 1) ? ivc_pkg::IVC_ONE << lfsr[28:24] : '0;
            fast_en = lfsr[5];
            fast_sel = lfsr[10:6];
            repeat (2) @(negedge clk);
            req = chan_req();
            chk(fast_irq, fast_en & src[fast_sel]);
            chk(normal_irq, |req);
            w = -1;
            for (int c = 31; c >= 0; c--) if (req[c] && (!busy || c < bchan)) w = c;
            exp.valid = 1'b1;
            exp.none = (w < 0);
            exp.channel = (w < 0) ? 5'h00 : w[4:0];
            exp.source = sel[exp.channel];
            exp.vector = tbl[exp.channel];
            u_ivc_core_model.read_ack(ans);
            chk(ans, exp);
            if (w >= 0) begin
                busy = 1'b1;
                bchan = w;
            end
            if (lfsr[30:29] != 2'h0) begin
                u_ivc_core_model.signal_done();
                busy = 1'b0;
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire
